//--- src/cfr_params.svh
// Offsets, reset values, rates, frame counts and timing counts of the
// clock and frame reference selector. Included by the design and the testbench.
`ifndef CFR_PARAMS_SVH
`define CFR_PARAMS_SVH
// Register word offsets
`define CFR_CLK_CFG_OFS 3'h0
`define CFR_FRM_CFG_OFS 3'h1
`define CFR_STATUS_OFS 3'h2
`define CFR_RATE_OFS 3'h3
`define CFR_TC_OFS 3'h4
// Reset values of the two configuration registers
`define CFR_CLK_CFG_RST 9'h000
`define CFR_FRM_CFG_RST 9'h000
// Base rates in Hz
`define CFR_HZ_32K 32'h0000_7D00
`define CFR_HZ_44K1 32'h0000_AC44
`define CFR_HZ_48K 32'h0000_BB80
// Frames per timecode second per count standard
`define CFR_FPS_FILM 5'h18
`define CFR_FPS_PAL 5'h19
`define CFR_FPS_NTSC 5'h1E
// Drop-frame: first frame number kept at a dropped minute
`define CFR_DROP_FIRST 5'h02
// Clock period in ps, internal frame period in ns (25 fps)
`define CFR_CLK_PS 5000
`define CFR_INT_FRAME_NS 40000000
// Reference activity timeout in ns
`define CFR_ACT_NS 50000000
`endif

//--- src/cfr_pkg.sv
// Types of the clock and frame reference selector.
// Assumes the constants header is compiled alongside.
package cfr_pkg;
  // Base sample rate
  typedef enum logic [1:0] {BASE_32K, BASE_44K1, BASE_48K, BASE_RSV} cfr_base_t;
  // Reference multiplier
  typedef enum logic [1:0] {MUL_1X, MUL_2X, MUL_4X, MUL_256X} cfr_mul_t;
  // Clock reference source
  typedef enum logic [3:0] {
    CSRC_INT, CSRC_WCLK, CSRC_AES1, CSRC_AES2, CSRC_SPDIF,
    CSRC_OPT, CSRC_VIDEO, CSRC_LTC, CSRC_MTC
  } cfr_csrc_t;
  // Frame reference source
  typedef enum logic [1:0] {FSRC_INT, FSRC_VIDEO, FSRC_LTC, FSRC_MTC} cfr_fsrc_t;
  // Timecode count standard
  typedef enum logic [1:0] {STD_FILM, STD_PAL, STD_NDROP, STD_DROP} cfr_std_t;
  // Frame rate (speed)
  typedef enum logic [2:0] {
    FR_23_976, FR_24, FR_24_9, FR_25, FR_29_97, FR_30
  } cfr_rate_t;
  // Clock configuration
  typedef struct packed {
    logic ext_ref;
    cfr_csrc_t src;
    cfr_mul_t mul;
    cfr_base_t base;
  } cfr_clk_cfg_t;
  // Frame configuration
  typedef struct packed {
    logic tri_level;
    logic dbl;
    cfr_rate_t rate;
    cfr_std_t std;
    cfr_fsrc_t src;
  } cfr_frm_cfg_t;
  // Avalon-MM request
  typedef struct packed {
    logic [2:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } cfr_av_req_t;
endpackage

//--- src/cfr_ref_select.sv
// Clock and frame reference selector: Avalon-MM register slave on
// ref_clk, reference pin capture on link_clk.
// Assumes reference pins are asynchronous and that link_clk runs free.
//
// Operation
// RL1 - Internal clock uses one of three base rates
// RL2 - Reference rate is base times chosen multiplier
// RL3 - Word clock reference spans 32k to 192k
// RL4 - Software keeps 32k base at unity multiplier
// RL5 - 256x only for word clock superclock
// RL6 - Word clock outputs multiply, digital outputs 1x/2x
// RL7 - Professional digital inputs usable as clock reference
// RL8 - Consumer digital inputs usable like professional ones
// RL9 - Timecode frames can derive the audio clock
// RL10 - Bi-level to 30 fps, tri-level to 60
// RL11 - Internal generator may follow an external reference
// RL12 - Four frame references: internal, video, LTC, MTC
// RL13 - Frame reference times frames and aligns audio
// RL14 - LTC aligns on leading frame edge
// RL15 - Standard frame rates from film to thirty
// RL16 - Doubled NTSC handled by doubling multiplier
// RL17 - Separate references share one master clock
// RL18 - Four count standards: film, PAL, ND, DF
// RL19 - Settings are independent, written separately
`timescale 1ns/1ps
`include "cfr_params.svh"
module cfr_ref_select #(
  // Periods in cycles; divide first so the terms stay within 32 bits
  parameter int unsigned INT_FRAME_CYC =
    `CFR_INT_FRAME_NS / (`CFR_CLK_PS / 1000),
  parameter int unsigned ACT_CYC = `CFR_ACT_NS / (`CFR_CLK_PS / 1000)
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Reference pins: wclk, aes1, aes2, spdif, opt, video, ltc, mtc
  input wire logic [7:0] ref_pins,
  // Clock and frame outputs
  output logic [31:0] eff_rate_hz,
  output cfr_pkg::cfr_mul_t wclk_out_mul,
  output cfr_pkg::cfr_mul_t aes_out_mul,
  output logic clk_locked,
  output logic frame_tick,
  output logic audio_phase_align
);
  import cfr_pkg::*;

  // Request bundle
  cfr_av_req_t req;
  assign req = '{address, read, write, byteenable, writedata};

  // Registers on ref_clk
  cfr_clk_cfg_t clk_cfg_q; // Clock configuration
  cfr_frm_cfg_t frm_cfg_q; // Frame configuration
  logic wait_q; // Waitrequest flop
  logic [31:0] rdata_q; // Read data flop
  logic [31:0] rate_q; // Effective reference rate
  cfr_mul_t wmul_q; // Word clock output multiplier
  cfr_mul_t amul_q; // Digital audio output multiplier
  logic lock_q; // Clock reference present
  logic tick_q; // Frame boundary pulse
  logic align_q; // Audio phase alignment pulse
  logic cfg_err_q; // Illegal combination seen
  logic [31:0] act_cnt_q; // Cycles since last clock event
  logic [31:0] div_q; // Internal frame divider
  logic [4:0] frame_q; // Timecode frame number
  logic [5:0] sec_q; // Timecode seconds
  logic [3:0] min_q; // Timecode minute units
  logic [2:0] ctgl_s_q; // Clock event toggle sync
  logic [2:0] ftgl_s_q; // Frame event toggle sync

  // Registers on link_clk
  logic [7:0] pin_s1_q; // First sync stage
  logic [7:0] pin_s2_q; // Second sync stage
  logic [7:0] pin_s3_q; // Edge history
  logic [6:0] lcfg_s1_q; // Config first stage
  logic [6:0] lcfg_s2_q; // Config second stage
  logic [6:0] lcfg_s3_q; // Config third stage, for the match check
  logic [6:0] lcfg_q; // Config accepted in the link domain
  logic ctgl_q; // Clock event toggle
  logic ftgl_q; // Frame event toggle

  // Bus decode; take marks the first cycle of a request, done the
  // answering one in which waitrequest is low
  wire acc = req.read | req.write;
  wire take = acc & wait_q;
  wire done = acc & ~wait_q;
  wire wr_clk = done & req.write & (req.address == `CFR_CLK_CFG_OFS);
  wire wr_frm = done & req.write & (req.address == `CFR_FRM_CFG_OFS);

  // Byte-lane merge; each setting lives in its own register
  wire [31:0] be_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
    {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
  wire [31:0] clk_old = {23'h0, clk_cfg_q};
  wire [31:0] frm_old = {23'h0, frm_cfg_q};
  wire [31:0] clk_new = (req.writedata & be_mask) | (clk_old & ~be_mask);
  wire [31:0] frm_new = (req.writedata & be_mask) | (frm_old & ~be_mask);
  wire cfr_clk_cfg_t clk_cfg_d = wr_clk ? cfr_clk_cfg_t'(clk_new[8:0])
                                        : clk_cfg_q; // RL19
  wire cfr_frm_cfg_t frm_cfg_d = wr_frm ? cfr_frm_cfg_t'(frm_new[8:0])
                                        : frm_cfg_q; // RL19

  // Base rate in Hz; reserved code falls back to 48 kHz
  wire [31:0] base_hz = (clk_cfg_q.base == BASE_32K) ? `CFR_HZ_32K :
    (clk_cfg_q.base == BASE_44K1) ? `CFR_HZ_44K1 : `CFR_HZ_48K; // RL1

  // Superclock multiplier only with word clock; else unity
  wire sclk_bad = (clk_cfg_q.mul == MUL_256X) &
                  (clk_cfg_q.src != CSRC_WCLK); // RL5
  wire cfr_mul_t mul_eff = sclk_bad ? MUL_1X : clk_cfg_q.mul; // RL5
  wire [3:0] mul_sh = (mul_eff == MUL_2X) ? 4'h1 :
    (mul_eff == MUL_4X) ? 4'h2 : (mul_eff == MUL_256X) ? 4'h8 : 4'h0;
  wire [31:0] rate_d = base_hz << mul_sh; // RL2 RL3

  // Digital audio outputs stay at 1x or 2x
  wire cfr_mul_t amul_d = (mul_eff == MUL_1X) ? MUL_1X : MUL_2X; // RL6

  // Video frame rate limits: bi-level to 30, tri-level to 60
  wire rate_std = (frm_cfg_q.rate <= FR_30); // RL15
  wire dbl_ok = ~frm_cfg_q.dbl | (frm_cfg_q.rate == FR_29_97); // RL16
  wire vid_ok = rate_std & dbl_ok &
                (~frm_cfg_q.dbl | frm_cfg_q.tri_level); // RL10
  wire frm_ok = (frm_cfg_q.src != FSRC_VIDEO) | vid_ok;
  wire cfg_err_d = sclk_bad | ~frm_ok | ~rate_std;

  // Events brought over from the link domain
  wire clk_evt = ctgl_s_q[2] ^ ctgl_s_q[1];
  wire ext_frm_evt = ftgl_s_q[2] ^ ftgl_s_q[1];

  // Internal crystal frame divider
  wire div_end = (div_q == INT_FRAME_CYC - 1);
  wire [31:0] div_d = div_end ? 32'h0 : div_q + 32'h1;

  // Frame boundary from the selected frame reference
  wire frame_evt = (frm_cfg_q.src == FSRC_INT) ? div_end
                 : (ext_frm_evt & frm_ok); // RL12 RL13

  // Lock: internal free-running is always locked
  // Otherwise lock falls after ACT_CYC cycles with no clock event
  wire int_free = (clk_cfg_q.src == CSRC_INT) & ~clk_cfg_q.ext_ref;
  wire act_hit = (act_cnt_q >= ACT_CYC - 1);
  wire [31:0] act_d = clk_evt ? 32'h0 : (act_hit ? act_cnt_q
                                                  : act_cnt_q + 32'h1);
  wire lock_d = int_free | clk_evt | (lock_q & ~act_hit); // RL7 RL8 RL9

  // Timecode frame count per standard
  // Drop-frame skips the first frames of a minute, not of minute zero
  wire [4:0] fps = (frm_cfg_q.std == STD_FILM) ? `CFR_FPS_FILM :
    (frm_cfg_q.std == STD_PAL) ? `CFR_FPS_PAL : `CFR_FPS_NTSC; // RL18
  wire frame_last = (frame_q >= fps - 5'h1);
  wire sec_last = (sec_q == 6'h3B);
  wire [3:0] min_nx = (min_q == 4'h9) ? 4'h0 : min_q + 4'h1;
  wire [5:0] sec_nx = sec_last ? 6'h0 : sec_q + 6'h1;
  wire [3:0] min_d = (frame_last & sec_last) ? min_nx : min_q;
  wire drop = (frm_cfg_q.std == STD_DROP) & sec_last &
              (min_nx != 4'h0); // RL18
  wire [4:0] frame_d = ~frame_last ? frame_q + 5'h1 :
                       (drop ? `CFR_DROP_FIRST : 5'h0);

  // Read mux; unmapped words read zero
  wire [31:0] status = {26'h0, cfg_err_q, lock_q, amul_q, wmul_q};
  wire [31:0] tc_word = {17'h0, min_q, sec_q, frame_q};
  wire [31:0] rd_mux =
    (req.address == `CFR_CLK_CFG_OFS) ? clk_old :
    (req.address == `CFR_FRM_CFG_OFS) ? frm_old :
    (req.address == `CFR_STATUS_OFS) ? status :
    (req.address == `CFR_RATE_OFS) ? rate_q :
    (req.address == `CFR_TC_OFS) ? tc_word : 32'h0;

  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= ~take;
      rdata_q <= take ? rd_mux : rdata_q;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_cfg_q <= cfr_clk_cfg_t'(`CFR_CLK_CFG_RST);
      frm_cfg_q <= cfr_frm_cfg_t'(`CFR_FRM_CFG_RST);
    end else begin
      clk_cfg_q <= clk_cfg_d;
      frm_cfg_q <= frm_cfg_d;
    end
  end

  // Derived rate and output multipliers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_q <= 32'h0;
      wmul_q <= MUL_1X;
      amul_q <= MUL_1X;
      cfg_err_q <= 1'b0;
    end else begin
      rate_q <= rate_d; // RL2
      wmul_q <= mul_eff; // RL6
      amul_q <= amul_d; // RL6
      cfg_err_q <= cfg_err_d;
    end
  end

  // Event toggle synchronisers into ref_clk
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctgl_s_q <= 3'h0;
      ftgl_s_q <= 3'h0;
    end else begin
      ctgl_s_q <= {ctgl_s_q[1:0], ctgl_q};
      ftgl_s_q <= {ftgl_s_q[1:0], ftgl_q};
    end
  end

  // Lock tracking and internal frame divider
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_cnt_q <= 32'h0;
      lock_q <= 1'b0;
      div_q <= 32'h0;
    end else begin
      act_cnt_q <= act_d;
      lock_q <= lock_d; // RL11
      div_q <= div_d; // RL12
    end
  end

  // Frame pulses: timecode frame and audio phase alignment
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 1'b0;
      align_q <= 1'b0;
    end else begin
      tick_q <= frame_evt; // RL13
      align_q <= frame_evt; // RL13
    end
  end

  // Timecode counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= 5'h0;
      sec_q <= 6'h0;
      min_q <= 4'h0;
    end else if (frame_evt) begin
      frame_q <= frame_d; // RL18
      sec_q <= frame_last ? sec_nx : sec_q;
      min_q <= min_d;
    end
  end

  // Config crosses as a quasi-static word; it is taken only after two
  // matching samples, so a word caught mid-change never steers selection
  wire lcfg_same = (lcfg_s2_q == lcfg_s3_q);
  wire [6:0] lcfg_d = lcfg_same ? lcfg_s2_q : lcfg_q;

  // Link domain: pins and config through two flops
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 8'h0;
      pin_s2_q <= 8'h0;
      pin_s3_q <= 8'h0;
      lcfg_s1_q <= 7'h0;
      lcfg_s2_q <= 7'h0;
      lcfg_s3_q <= 7'h0;
      lcfg_q <= 7'h0;
    end else begin
      pin_s1_q <= ref_pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      lcfg_s1_q <= {clk_cfg_q.ext_ref, clk_cfg_q.src, frm_cfg_q.src};
      lcfg_s2_q <= lcfg_s1_q;
      lcfg_s3_q <= lcfg_s2_q;
      lcfg_q <= lcfg_d;
    end
  end

  // Link domain source selection
  wire [7:0] rise = pin_s2_q & ~pin_s3_q;
  wire l_ext = lcfg_q[6];
  wire [3:0] l_csrc = lcfg_q[5:2];
  wire [1:0] l_fsrc = lcfg_q[1:0];
  wire [2:0] c_idx = 3'(l_csrc - 4'h1);
  wire c_rise = (l_csrc == CSRC_INT) ? (l_ext & rise[0]) // RL11
              : (l_csrc > CSRC_MTC) ? 1'b0 : rise[c_idx]; // RL7 RL8 RL9
  wire f_rise = (l_fsrc == FSRC_VIDEO) ? rise[5] :
                (l_fsrc == FSRC_LTC) ? rise[6] : // RL14
                (l_fsrc == FSRC_MTC) ? rise[7] : 1'b0;

  // Link domain event toggles
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctgl_q <= 1'b0;
      ftgl_q <= 1'b0;
    end else begin
      ctgl_q <= ctgl_q ^ c_rise;
      ftgl_q <= ftgl_q ^ f_rise; // RL12
    end
  end

  // Outputs from flops
  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign eff_rate_hz = rate_q;
  assign wclk_out_mul = wmul_q;
  assign aes_out_mul = amul_q;
  assign clk_locked = lock_q;
  assign frame_tick = tick_q;
  assign audio_phase_align = align_q;

  // Checks on ref_clk
  base_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL1
    ##1 (clk_cfg_q.base == BASE_32K && !$past(wr_clk))
    |=> rate_q == (`CFR_HZ_32K << $past(mul_sh)))
    else $error("base rate not 32 kHz");
  rate_mul_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
    (clk_cfg_q.base == BASE_48K && mul_eff == MUL_4X)
    |=> rate_q == 32'h0002_EE00)
    else $error("48k times 4 is not 192k");
  superclk_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL5
    (wmul_q == MUL_256X) |-> $past(clk_cfg_q.src) == CSRC_WCLK)
    else $error("256x without word clock");
  aes_mult_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6
    ##1 (amul_q == MUL_1X || amul_q == MUL_2X) &&
    ((wmul_q == MUL_1X) == (amul_q == MUL_1X)))
    else $error("digital output multiplier out of range");
  video_lim_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
    (frm_cfg_q.src == FSRC_VIDEO && frm_cfg_q.dbl && !frm_cfg_q.tri_level)
    [*2] |=> !frame_tick)
    else $error("double rate taken on bi-level sync");
  frame_pulse_a: assert property ( // RL13
    @(posedge ref_clk) disable iff (!rst_b)
    frame_evt |=> frame_tick && audio_phase_align ##1 !frame_tick)
    else $error("frame pulse not aligned");
  lock_evt_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
    clk_evt |=> clk_locked)
    else $error("clock event without lock");
  tc_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL18
    (frame_evt && frame_last && frm_cfg_q.std != STD_DROP)
    |=> frame_q == 5'h0)
    else $error("frame count did not wrap");
  cfg_indep_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL19
    wr_frm |=> $stable(clk_cfg_q))
    else $error("frame write disturbed clock setting");
  int_div_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL12
    div_q < INT_FRAME_CYC)
    else $error("internal frame divider overran");
  bus_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL19
    take |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle long");
  cfg_err_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL5
    sclk_bad |=> cfg_err_q)
    else $error("refused superclock not flagged");
  lock_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
    (act_hit && !clk_evt && !int_free) |=> !clk_locked)
    else $error("lock held without clock events");
  int_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL11
    int_free |=> clk_locked)
    else $error("free-running internal clock not locked");

  // Check on link_clk
  ltc_edge_a: assert property (@(posedge link_clk) disable iff (!rst_b) // RL14
    (l_fsrc == FSRC_LTC && pin_s2_q[6] && !pin_s3_q[6])
    |=> ftgl_q != $past(ftgl_q))
    else $error("LTC leading edge missed");
endmodule

//--- verif/cfr_src_model.sv
// Model of the outside reference sources: pulse trains on the pins.
// Assumes link_clk stands for the one master clock that all sources share.
`timescale 1ns/1ps
module cfr_src_model (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst_b,
  // Pins that should carry pulses
  input wire logic [7:0] en,
  // Pin drive and count of pulses sent
  output logic [7:0] ref_pins,
  output int n_rise
);
  logic [2:0] ph_q; // Phase within an eight-cycle period
  logic [7:0] on_q; // Pins pulsing in this period

  // Pulses are 3 link cycles high and 5 low, so both levels stay long
  assign ref_pins = (ph_q < 3'h3) ? on_q : 8'h00;

  // Every source runs from the same link clock, so no drift between them
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q <= 3'h0;
      on_q <= 8'h00;
      n_rise <= 0;
    end else begin
      ph_q <= ph_q + 3'h1;
      // New period: take the enable set and count the coming pulse
      if (ph_q == 3'h7) begin
        on_q <= en;
        if (|en) begin
          n_rise <= n_rise + 1;
        end
      end
    end
  end
endmodule

//--- verif/cfr_ref_select_tb_top.sv
// Self-checking bench of the reference selector over its register bus.
// Assumes the selector is built with short frame and activity counts.
`timescale 1ns/1ps
`include "cfr_params.svh"
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module cfr_ref_select_tb_top;
  import cfr_pkg::*;
  // Clocks, reset and bus
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] address;
  logic read, write;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, eff_rate_hz, rd, hz, cfg;
  logic waitrequest, clk_locked, frame_tick, audio_phase_align;
  cfr_mul_t wclk_out_mul, aes_out_mul;
  // Reference pins and their enables
  logic [7:0] ref_pins, src_en;
  logic [4:0] mx;
  // Frame configurations and whether video, LTC or MTC events count under them
  logic [8:0] fcfg [7] = '{9'h031, 9'h1C1, 9'h0C1, 9'h1B1, 9'h071,
                           9'h002, 9'h003};
  logic facc [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [4:0] fmax [4] = '{`CFR_FPS_FILM - 5'h01, `CFR_FPS_PAL - 5'h01,
                           `CFR_FPS_NTSC - 5'h01, `CFR_FPS_NTSC - 5'h01};
  int n_rise, nticks = 0, t0, r0, cycles = 0;
  int mismatches = 0, tests_run = 0;

  // System clock at 200 MHz
  always #2.5 ref_clk = ~ref_clk;
  // Link clock at 80 ns, offset so its edges never meet the system clock
  initial begin
    #13.1;
    forever #40 link_clk = ~link_clk;
  end

  cfr_ref_select #(.INT_FRAME_CYC(20), .ACT_CYC(200)) dut (
    .ref_clk(ref_clk), .link_clk(link_clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ref_pins(ref_pins),
    .eff_rate_hz(eff_rate_hz), .wclk_out_mul(wclk_out_mul),
    .aes_out_mul(aes_out_mul), .clk_locked(clk_locked),
    .frame_tick(frame_tick), .audio_phase_align(audio_phase_align));

  cfr_src_model src (.link_clk(link_clk), .rst_b(rst_b), .en(src_en),
    .ref_pins(ref_pins), .n_rise(n_rise));

  // Count frame ticks; the phase pulse must share each tick's cycle
  always @(posedge ref_clk) begin
    if (frame_tick === 1'b1) begin
      nticks++;
    end
    if (rst_b && frame_tick !== audio_phase_align) begin
      `CHK(audio_phase_align, frame_tick)
    end
  end

  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      stop_test();
    end
  end

  // Print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Write held until the edge that sees waitrequest low
  task automatic av_write(input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    @(posedge ref_clk iff waitrequest === 1'b0);
    write <= 1'b0;
  endtask

  // Read; data taken at the edge that sees waitrequest low
  task automatic av_read(input logic [2:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    read <= 1'b1;
    @(posedge ref_clk iff waitrequest === 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask

  initial begin
    address = 3'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0;
    src_en = 8'h00;
    wait_cyc(16);
    rst_b <= 1'b1;
    wait_cyc(3);
    // Defaults after reset
    `CHK(eff_rate_hz, `CFR_HZ_32K)
    `CHK(clk_locked, 1'b1)
    av_read(`CFR_CLK_CFG_OFS, rd);
    `CHK(rd, 32'h0)
    // Every base with every multiplier, word clock source; 32k stays 1x
    for (int b = 0; b < 3; b++) begin
      for (int m = 0; m < 4; m++) begin
        if (b == 0 && m > 0) continue;
        hz = (b == 0) ? `CFR_HZ_32K : (b == 1) ? `CFR_HZ_44K1 : `CFR_HZ_48K;
        cfg = {24'h0, 4'h1, m[1:0], b[1:0]};
        av_write(`CFR_CLK_CFG_OFS, cfg);
        wait_cyc(3);
        `CHK(eff_rate_hz, (m == 3) ? hz << 8 : hz << m)
        av_read(`CFR_RATE_OFS, rd);
        `CHK(rd, (m == 3) ? hz << 8 : hz << m)
        `CHK(wclk_out_mul, cfr_mul_t'(m[1:0]))
        if (m < 2) `CHK(aes_out_mul, cfr_mul_t'(m[1:0]))
        else `CHK(aes_out_mul[1], 1'b0)
        av_read(`CFR_CLK_CFG_OFS, rd);
        `CHK(rd, cfg)
      end
    end
    // 256x refused for a source other than word clock
    av_write(`CFR_CLK_CFG_OFS, 32'h0000_000E);
    wait_cyc(3);
    `CHK(eff_rate_hz, `CFR_HZ_48K)
    // Status: error flag and lock set, both multipliers back at 1x
    av_read(`CFR_STATUS_OFS, rd);
    `CHK(rd, 32'h0000_0030)
    // Read-only and unmapped places leave the settings alone
    av_write(`CFR_RATE_OFS, 32'h0000_1234);
    av_write(3'h6, 32'hFFFF_FFFF);
    av_read(3'h6, rd);
    `CHK(rd, 32'h0)
    av_read(`CFR_RATE_OFS, rd);
    `CHK(rd, `CFR_HZ_48K)
    av_write(`CFR_FRM_CFG_OFS, 32'h0000_0031);
    av_read(`CFR_CLK_CFG_OFS, rd);
    `CHK(rd, 32'h0000_000E)
    // Each outside source locks while it pulses and unlocks when silent
    for (int s = 1; s <= 8; s++) begin
      av_write(`CFR_CLK_CFG_OFS, {24'h0, s[3:0], 4'h0});
      src_en <= 8'h01 << (s - 1);
      wait_cyc(400);
      `CHK(clk_locked, 1'b1)
      src_en <= 8'h00;
      wait_cyc(400);
      `CHK(clk_locked, 1'b0)
    end
    // Internal generator following the word clock pin
    av_write(`CFR_CLK_CFG_OFS, 32'h0000_0100);
    wait_cyc(400);
    `CHK(clk_locked, 1'b0)
    src_en <= 8'h01;
    wait_cyc(400);
    `CHK(clk_locked, 1'b1)
    src_en <= 8'h00;
    av_write(`CFR_CLK_CFG_OFS, 32'h0);
    // Internal frame reference ticks every 20 cycles
    av_write(`CFR_FRM_CFG_OFS, 32'h0);
    t0 = nticks;
    wait_cyc(400);
    `CHK(nticks - t0, 20)
    // Outside frame references: one tick per accepted event
    for (int i = 0; i < 7; i++) begin
      av_write(`CFR_FRM_CFG_OFS, {23'h0, fcfg[i]});
      wait_cyc(40);
      t0 = nticks;
      r0 = n_rise;
      src_en <= 8'h01 << (fcfg[i][1:0] + 4);
      wait_cyc(640);
      src_en <= 8'h00;
      wait_cyc(200);
      `CHK(nticks - t0, facc[i] ? n_rise - r0 : 0)
    end
    // Every frame rate code is held as written
    for (int r = 0; r < 6; r++) begin
      av_write(`CFR_FRM_CFG_OFS, {25'h0, r[2:0], 4'h0});
      av_read(`CFR_FRM_CFG_OFS, rd);
      `CHK(rd, {25'h0, r[2:0], 4'h0})
    end
    // Highest frame number reached under each count standard
    for (int s = 0; s < 4; s++) begin
      av_write(`CFR_FRM_CFG_OFS, {28'h0, s[1:0], 2'b00});
      mx = 5'h00;
      repeat (250) begin
        av_read(`CFR_TC_OFS, rd);
        if (rd[4:0] > mx) mx = rd[4:0];
      end
      `CHK(mx, fmax[s])
    end
    stop_test();
  end
endmodule
